/* File: urx_receiver.v */
/*
  Receive half of a serial transceiver: start detection, majority sampling,
  shift register, parity check, two-entry receive buffer with status bits.
  Assumes a one-cycle sample tick at 16x (8x double speed) the baud rate,
  and that all inputs, the transfer clock pin included, are synchronous.
*/
// What this block does
// - Enable bit activates receiver and claims the serial input pin.
// - Synchronous mode samples bits on the external transfer clock.
// - After valid start, sample bits into shift register up to first stop.
// - After first stop bit, frame moves into buffer read via data register.
// - Unused upper data bits read zero for short characters.
// - Ninth bit kept per entry; data read advances ninth bit and flags.
// - Receive-complete flag is one exactly when buffer holds unread data.
// - Enabled receive interrupt is a level following receive-complete.
// - Error flags stored with their frame, shown for next entry.
// - Status writes never change error flags; errors raise no interrupt.
// - Frame error equals first stop bit sampled low; stop count ignored.
// - Overrun set when buffer full, frame waiting, and new start detected.
// - Overrun indication cleared when a frame moves into the buffer.
// - With parity enabled, compute parity and store comparison with frame.
// - Parity error only if checked at reception; zero otherwise.
// - Disable is immediate: drop reception, flush buffer, release pin.
// - Bit period has 16 or 8 samples; centre three decide by majority.
// - Start bit validated by samples 8-10 or 4-6; rejected if mostly high.
`timescale 1ns/100ps
`include "urx_regs.vh"

module urx_receiver
(
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       serial_input_pin,
  input  wire       external_transfer_clock_pin,
  input  wire       receiver_enable_bit,
  input  wire       sync_mode,
  input  wire       double_speed,
  input  wire       sample_tick,
  input  wire [2:0] character_size_field,
  input  wire       parity_enable_bit,
  input  wire       parity_odd_select_bit,
  input  wire       stop_bit_count_select,
  input  wire       receive_complete_irq_enable,
  input  wire       data_read_strobe,
  output reg  [7:0] serial_data_register,
  output reg        received_ninth_bit,
  output reg        frame_error_flag,
  output reg        overrun_flag,
  output reg        parity_error_flag,
  output reg        receive_complete_flag,
  output reg        receive_complete_irq,
  output reg        pin_override
);

  // ----------------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------------
  reg [1:0]  state_reg;
  reg [4:0]  sample_cnt_reg;
  reg [3:0]  bit_idx_reg;
  reg [1:0]  vote_reg;
  reg [8:0]  shift_reg;
  reg        parity_acc_reg;
  reg        parity_err_reg;
  reg        xck_prev_reg;
  reg        lost_frame_reg;
  reg        pend_valid_reg;
  reg [`URX_ENTRY_W-1:0] pend_entry_reg;
  reg        overrun_pend_reg;

  wire [`URX_ENTRY_W-1:0] head_data;
  wire       fifo_empty;
  wire       fifo_full;

  reg  [3:0] data_bits;
  wire [4:0] samples_per_bit;
  wire [4:0] vote_first;
  reg        decide_now;
  reg        bit_val;
  wire [4:0] vote_last;
  wire [3:0] parity_idx;
  wire [3:0] stop_idx;
  wire       xck_rise;
  wire       pop;
  wire       push;

  // ----------------------------------------------------------------------
  // Frame format decode
  // ----------------------------------------------------------------------
  // Data bit count from the character size code.
  always @*
  begin
    case (character_size_field)
      `URX_CSZ_5: data_bits = `URX_BITS_5;
      `URX_CSZ_6: data_bits = `URX_BITS_6;
      `URX_CSZ_7: data_bits = `URX_BITS_7;
      `URX_CSZ_9: data_bits = `URX_BITS_9;
      default:    data_bits = `URX_BITS_8;
    endcase
  end

  // Sample rate and centre vote positions for the selected speed.
  assign samples_per_bit = double_speed ? `URX_SAMPLES_DOUBLE : `URX_SAMPLES_NORMAL;
  assign vote_first = double_speed ? `URX_VOTE_FIRST_DOUBLE : `URX_VOTE_FIRST_NORMAL;
  assign vote_last  = vote_first + 5'h02;
  assign parity_idx = data_bits + 4'h1;
  // The stop bit follows the parity bit only when parity is enabled.
  assign stop_idx   = parity_enable_bit ? data_bits + 4'h2 : data_bits + 4'h1;
  assign xck_rise   = external_transfer_clock_pin && !xck_prev_reg;

  // ----------------------------------------------------------------------
  // Bit decision strobe and value
  // ----------------------------------------------------------------------
  // Asynchronous mode votes over three centre samples; synchronous mode
  // takes the pin level at each rising transfer clock edge.
  always @*
  begin
    if (sync_mode)
    begin
      decide_now = xck_rise && (state_reg == `URX_ST_RECV);
      bit_val    = serial_input_pin;
    end
    else
    begin
      decide_now = sample_tick && (state_reg == `URX_ST_RECV) &&
                   (sample_cnt_reg == vote_last);
      bit_val    = (vote_reg[0] & vote_reg[1]) | (vote_reg[0] & serial_input_pin) |
                   (vote_reg[1] & serial_input_pin);
    end
  end

  // ----------------------------------------------------------------------
  // Buffer handshake
  // ----------------------------------------------------------------------
  assign pop  = data_read_strobe && !fifo_empty && receiver_enable_bit;
  assign push = pend_valid_reg && (!fifo_full || pop);

  // ----------------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------------
  // Start detection, sampling, shifting and frame completion.
  always @(posedge sys_clk)
  begin
    if (srst || !receiver_enable_bit)
    begin
      state_reg        <= `URX_ST_IDLE;
      sample_cnt_reg   <= `URX_SAMPLE_FIRST;
      bit_idx_reg      <= 4'h0;
      vote_reg         <= 2'h0;
      shift_reg        <= 9'h000;
      parity_acc_reg   <= 1'b0;
      parity_err_reg   <= 1'b0;
      lost_frame_reg   <= 1'b0;
      pend_valid_reg   <= 1'b0;
      pend_entry_reg   <= {`URX_ENTRY_W{1'b0}};
      overrun_pend_reg <= 1'b0;
    end
    else
    begin
      // Hand a waiting frame to the buffer as soon as there is room.
      if (push)
      begin
        pend_valid_reg   <= 1'b0;
        overrun_pend_reg <= 1'b0;
      end
      case (state_reg)
        `URX_ST_IDLE:
        begin
          // A low level on a sample point opens a frame; the next sample counts as sample 1.
          if (!serial_input_pin && (sync_mode ? xck_rise : sample_tick))
          begin
            state_reg      <= `URX_ST_RECV;
            sample_cnt_reg <= `URX_SAMPLE_FIRST;
            bit_idx_reg    <= sync_mode ? 4'h1 : 4'h0;
            shift_reg      <= 9'h000;
            parity_acc_reg <= 1'b0;
            parity_err_reg <= 1'b0;
            lost_frame_reg <= pend_valid_reg && !push;
            if (sync_mode && fifo_full && pend_valid_reg && !push)
            begin
              overrun_pend_reg <= 1'b1;
            end
          end
        end
        `URX_ST_RECV:
        begin
          // Sample counting inside a bit period.
          if (!sync_mode && sample_tick)
          begin
            if (sample_cnt_reg == vote_first)
            begin
              vote_reg[0] <= serial_input_pin;
            end
            if (sample_cnt_reg == vote_first + 5'h01)
            begin
              vote_reg[1] <= serial_input_pin;
            end
            if (sample_cnt_reg == samples_per_bit)
            begin
              sample_cnt_reg <= `URX_SAMPLE_FIRST;
              bit_idx_reg    <= bit_idx_reg + 4'h1;
            end
            else
            begin
              sample_cnt_reg <= sample_cnt_reg + 5'h01;
            end
          end
          if (sync_mode && xck_rise)
          begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
          end
          if (decide_now)
          begin
            if (bit_idx_reg == 4'h0)
            begin
              if (bit_val)
              begin
                state_reg <= `URX_ST_IDLE;
              end
              else if (fifo_full && pend_valid_reg && !push)
              begin
                overrun_pend_reg <= 1'b1;
              end
            end
            else if (bit_idx_reg <= data_bits)
            begin
              shift_reg[bit_idx_reg - 4'h1] <= bit_val;
              parity_acc_reg <= parity_acc_reg ^ bit_val;
            end
            else if (parity_enable_bit && (bit_idx_reg == parity_idx))
            begin
              parity_err_reg <= parity_acc_reg ^ bit_val ^ parity_odd_select_bit;
            end
            if ((bit_idx_reg != 4'h0) && (bit_idx_reg == stop_idx))
            begin
              // The first stop bit closes the frame; any second one is idle.
              state_reg <= `URX_ST_IDLE;
              if (!lost_frame_reg)
              begin
                pend_valid_reg <= 1'b1;
                pend_entry_reg[`URX_E_DATA_HI:0] <= shift_reg[7:0];
                pend_entry_reg[`URX_E_NINTH] <=
                  (character_size_field == `URX_CSZ_9) ? shift_reg[8] : 1'b0;
                pend_entry_reg[`URX_E_FE]  <= !bit_val;
                pend_entry_reg[`URX_E_PE]  <= parity_enable_bit & parity_err_reg;
                pend_entry_reg[`URX_E_DOR] <= 1'b0;
              end
            end
          end
        end
        default:
        begin
          state_reg <= `URX_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------------
  urx_rx_fifo
  #(
    .WIDTH (`URX_ENTRY_W),
    .DEPTH (`URX_BUF_DEPTH),
    .PTR_W (1)
  )
  u_fifo
  (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .flush     (!receiver_enable_bit),
    .push      (push),
    .push_data ({pend_entry_reg[`URX_E_PE], overrun_pend_reg,
                 pend_entry_reg[`URX_E_FE:0]}),
    .pop       (pop),
    .head_data (head_data),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // ----------------------------------------------------------------------
  // Register-side view
  // ----------------------------------------------------------------------
  // Outputs show the head entry; they read zero when the buffer is empty.
  // Status writes have no path here, so error flags cannot be altered.
  always @(posedge sys_clk)
  begin
    if (srst || !receiver_enable_bit || fifo_empty)
    begin
      serial_data_register  <= 8'h00;
      received_ninth_bit    <= 1'b0;
      frame_error_flag      <= 1'b0;
      overrun_flag          <= 1'b0;
      parity_error_flag     <= 1'b0;
      receive_complete_flag <= 1'b0;
      receive_complete_irq  <= 1'b0;
    end
    else
    begin
      serial_data_register  <= head_data[`URX_E_DATA_HI:0];
      received_ninth_bit    <= head_data[`URX_E_NINTH];
      frame_error_flag      <= head_data[`URX_E_FE];
      overrun_flag          <= head_data[`URX_E_DOR];
      parity_error_flag     <= head_data[`URX_E_PE];
      receive_complete_flag <= 1'b1;
      receive_complete_irq  <= receive_complete_irq_enable;
    end
  end

  // Pin ownership follows the enable bit; the transfer clock history feeds edge detection.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      pin_override <= 1'b0;
      xck_prev_reg <= 1'b0;
    end
    else
    begin
      pin_override <= receiver_enable_bit;
      xck_prev_reg <= external_transfer_clock_pin;
    end
  end

endmodule // urx_receiver

/* File: urx_regs.vh */
/*
  Constants of the receive half of the serial transceiver: sample counts,
  vote positions, state codes, character size codes and buffer entry layout.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef URX_REGS_VH
`define URX_REGS_VH

// ----------------------------------------------------------------------
// Sampling of one bit period
// ----------------------------------------------------------------------
`define URX_SAMPLES_NORMAL 5'h10
`define URX_SAMPLES_DOUBLE 5'h08
`define URX_VOTE_FIRST_NORMAL 5'h08
`define URX_VOTE_FIRST_DOUBLE 5'h04
`define URX_SAMPLE_FIRST 5'h01

// ----------------------------------------------------------------------
// Character size codes and data bit counts
// ----------------------------------------------------------------------
`define URX_CSZ_5 3'h0
`define URX_CSZ_6 3'h1
`define URX_CSZ_7 3'h2
`define URX_CSZ_8 3'h3
`define URX_CSZ_9 3'h7
`define URX_BITS_5 4'h5
`define URX_BITS_6 4'h6
`define URX_BITS_7 4'h7
`define URX_BITS_8 4'h8
`define URX_BITS_9 4'h9

// ----------------------------------------------------------------------
// Receiver states, one-hot
// ----------------------------------------------------------------------
`define URX_ST_IDLE 2'h1
`define URX_ST_RECV 2'h2

// ----------------------------------------------------------------------
// Buffer entry layout: {pe, dor, fe, ninth, data[7:0]}
// ----------------------------------------------------------------------
`define URX_ENTRY_W 12
`define URX_E_DATA_HI 7
`define URX_E_NINTH 8
`define URX_E_FE 9
`define URX_E_DOR 10
`define URX_E_PE 11
`define URX_BUF_DEPTH 2

`endif

/* File: urx_rx_fifo.v */
/*
  Receive buffer: a small first-in first-out store of complete frames with
  their status bits.
  Assumes the caller only pushes when there is room or a pop happens in the
  same cycle, and only pops when not empty.
*/
`timescale 1ns/100ps
`include "urx_regs.vh"

module urx_rx_fifo
#(
  parameter WIDTH = `URX_ENTRY_W,
  parameter DEPTH = `URX_BUF_DEPTH,
  parameter PTR_W = 1
)
(
  input  wire             sys_clk,
  input  wire             srst,
  input  wire             flush,
  input  wire             push,
  input  wire [WIDTH-1:0] push_data,
  input  wire             pop,
  output wire [WIDTH-1:0] head_data,
  output wire             empty,
  output wire             full
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_reg;
  reg [PTR_W-1:0] rd_ptr_reg;
  reg [PTR_W:0]   count_reg;

  // ----------------------------------------------------------------------
  // Status and head
  // ----------------------------------------------------------------------
  assign empty     = (count_reg == {(PTR_W+1){1'b0}});
  assign full      = (count_reg == DEPTH[PTR_W:0]);
  assign head_data = mem[rd_ptr_reg];

  // Pointer and count update; flush empties the store at once.
  always @(posedge sys_clk)
  begin
    if (srst || flush)
    begin
      wr_ptr_reg <= {PTR_W{1'b0}};
      rd_ptr_reg <= {PTR_W{1'b0}};
      count_reg  <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr_reg] <= push_data;
        wr_ptr_reg      <= (wr_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ?
                           {PTR_W{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[PTR_W-1:0] - 1'b1) ?
                      {PTR_W{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop)
      begin
        count_reg <= count_reg + 1'b1;
      end
      else if (pop && !push)
      begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule // urx_rx_fifo

/* File: urx_line_model.sv */
/*
  Remote serial transmitter that drives one frame on the receive line per request.
  Assumes the bench supplies the receiver's sample tick, so that one bit lasts
  16 ticks, or 8 at double speed, exactly as the receiver counts them.
*/
`timescale 1ns/100ps

module urx_line_model
(
  input  wire        sys_clk,
  input  wire        sample_tick,
  input  wire        double_speed,
  input  wire        go,
  input  wire [11:0] frame_bits,
  input  wire [3:0]  frame_len,
  output reg         line,
  output reg         busy
);
  reg [12:0] shift_reg;
  reg [3:0]  left_reg;
  reg [3:0]  tcnt_reg;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  // The idle line rests high.
  initial
  begin
    line = 1'b1;
    busy = 1'b0;
  end

  // A low start bit, then the frame LSB first, each bit one full period.
  always @(posedge sys_clk)
    if (!busy)
    begin
      if (go)
      begin
        busy      <= 1'b1;
        shift_reg <= {frame_bits, 1'b0};
        left_reg  <= frame_len + 4'h1;
        tcnt_reg  <= 4'h0;
      end
    end
    else if (sample_tick)
    begin
      if (tcnt_reg == 4'h0)
      begin
        if (left_reg == 4'h0)
        begin
          line <= 1'b1;
          busy <= 1'b0;
        end
        else
        begin
          line      <= shift_reg[0];
          shift_reg <= shift_reg >> 1;
          left_reg  <= left_reg - 4'h1;
        end
      end
      tcnt_reg <= (tcnt_reg + 4'h1) & (double_speed ? 4'h7 : 4'hF);
    end
endmodule // urx_line_model

/* File: urx_receiver_asserts.sv */
/*
  Checker of the receive block: flag, interrupt, flush and entry relations.
  Assumes it is bound to urx_receiver, whose ports all share sys_clk.
*/
`timescale 1ns/100ps
`include "urx_regs.vh"

module urx_receiver_asserts
(
  input wire       sys_clk,
  input wire       srst,
  input wire       receiver_enable_bit,
  input wire [2:0] character_size_field,
  input wire       parity_enable_bit,
  input wire       receive_complete_irq_enable,
  input wire       data_read_strobe,
  input wire [7:0] serial_data_register,
  input wire       received_ninth_bit,
  input wire       frame_error_flag,
  input wire       overrun_flag,
  input wire       parity_error_flag,
  input wire       receive_complete_flag,
  input wire       receive_complete_irq,
  input wire       pin_override
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Interrupt level follows the flag while enabled, and is quiet otherwise.
  a_irq_follows: assert property (
    receive_complete_flag && receive_complete_irq_enable && $past(receive_complete_flag)
    && $past(receive_complete_irq_enable) |-> receive_complete_irq) else $error("irq low");
  a_irq_quiet: assert property (
    !receive_complete_flag && !$past(receive_complete_flag) |-> !receive_complete_irq)
    else $error("irq without data");
  a_irq_masked: assert property (
    !receive_complete_irq_enable && !$past(receive_complete_irq_enable)
    |-> !receive_complete_irq) else $error("irq while masked");
  // Disable flushes the buffer and hands the pin back.
  a_disable_flush: assert property (
    (!receiver_enable_bit)[*4] |-> !receive_complete_flag && !pin_override)
    else $error("buffer not flushed");
  a_pin_follows: assert property (
    !$past(srst) |-> pin_override == $past(receiver_enable_bit)) else $error("pin owner");
  // An empty buffer shows zero data and clear status.
  a_empty_zero: assert property (
    !receive_complete_flag |-> serial_data_register == 8'h00 && !received_ninth_bit
    && !frame_error_flag && !overrun_flag && !parity_error_flag) else $error("stale head");
  // Without a read the head entry stays put.
  a_head_holds: assert property (
    (receiver_enable_bit && !data_read_strobe && receive_complete_flag)[*5]
    |=> $stable(serial_data_register) && receive_complete_flag) else $error("head moved");
  a_short_upper: assert property (
    receive_complete_flag && character_size_field == `URX_CSZ_5
    |-> serial_data_register[7:5] == 3'h0) else $error("upper bits set");
  a_ninth_zero: assert property (
    receive_complete_flag && character_size_field != `URX_CSZ_9 |-> !received_ninth_bit)
    else $error("ninth bit set");
  a_parity_off: assert property (
    !parity_enable_bit |-> !parity_error_flag) else $error("parity error while off");

  c_overrun: cover property (overrun_flag && receive_complete_flag);
  c_frame_err: cover property (frame_error_flag);
  c_parity_err: cover property (parity_error_flag);
  c_irq: cover property (receive_complete_irq);
endmodule // urx_receiver_asserts

bind urx_receiver urx_receiver_asserts u_chk (.sys_clk, .srst, .receiver_enable_bit,
  .character_size_field, .parity_enable_bit, .receive_complete_irq_enable,
  .data_read_strobe, .serial_data_register, .received_ninth_bit, .frame_error_flag,
  .overrun_flag, .parity_error_flag, .receive_complete_flag, .receive_complete_irq,
  .pin_override);

/* File: urx_receiver_tb.sv */
/*
  Bench of the receive block: a line model sends frames, a reader scores
  each buffer entry against the expectations queued by the sender.
  Assumes the line model and the checker are compiled before it.
*/
`timescale 1ns/100ps
`include "urx_regs.vh"

module uart_receiver_tb;
  reg        sys_clk, srst, sample_tick, sync_mode, external_transfer_clock_pin;
  reg        receiver_enable_bit, double_speed, parity_enable_bit, parity_odd_select_bit;
  reg        stop_bit_count_select, receive_complete_irq_enable, data_read_strobe;
  reg        go, hold_rd;
  reg [2:0]  character_size_field;
  reg [11:0] frame_bits, got;
  reg [11:0] expq[$];
  reg [3:0]  frame_len;
  reg [1:0]  tdiv;
  reg [31:0] r;
  wire       serial_input_pin, busy, received_ninth_bit, frame_error_flag, overrun_flag;
  wire       parity_error_flag, receive_complete_flag, receive_complete_irq, pin_override;
  wire [7:0] serial_data_register;
  integer    fails, n_checks, seed, i;

  urx_receiver u_dut (.sys_clk, .srst, .serial_input_pin, .external_transfer_clock_pin,
    .receiver_enable_bit, .sync_mode, .double_speed, .sample_tick, .character_size_field,
    .parity_enable_bit, .parity_odd_select_bit, .stop_bit_count_select,
    .receive_complete_irq_enable, .data_read_strobe, .serial_data_register,
    .received_ninth_bit, .frame_error_flag, .overrun_flag, .parity_error_flag,
    .receive_complete_flag, .receive_complete_irq, .pin_override);
  urx_line_model u_line (.sys_clk, .sample_tick, .double_speed, .go, .frame_bits,
    .frame_len, .line(serial_input_pin), .busy);

  // ----------------------------------------------------------------
  // Clock, sample tick and report
  // ----------------------------------------------------------------
  // The clock runs at 100 MHz; the sample tick pulses every fourth cycle.
  // In synchronous mode the transfer clock rises in the middle of each bit.
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk)
  begin
    tdiv        <= tdiv + 2'h1;
    sample_tick <= (tdiv == 2'h3);
    external_transfer_clock_pin <= sync_mode & u_line.busy & u_line.tcnt_reg[3];
  end

  task miss(input string msg);
  begin
    fails = fails + 1;
    $display("wrong value at %0t: %0s", $time, msg);
  end
  endtask

  task conclude;
  begin
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // ----------------------------------------------------------------
  // Sender and reader
  // ----------------------------------------------------------------
  // Waits, bounded, until the line model reaches the given busy state.
  task wait_busy(input lvl);
    integer k;
  begin
    for (k = 0; busy !== lvl; k = k + 1)
    begin
      if (k == 4000)
      begin
        miss("line model stuck");
        conclude;
      end
      @(negedge sys_clk);
    end
  end
  endtask

  // Builds a frame in the current format, notes its expected entry, launches it.
  task launch(input [8:0] d, input bpar, input bstop, input dorx, input keep);
    reg [3:0] n;
    reg [8:0] m;
    reg       p;
  begin
    n = (character_size_field == `URX_CSZ_9) ? 4'h9 : (character_size_field < 3'h4) ?
        {1'b0, character_size_field} + 4'h5 : 4'h8;
    m = d & ((9'h001 << n) - 9'h001);
    p = ^m ^ parity_odd_select_bit ^ bpar;
    frame_bits = {3'h0, m} | ({11'h000, p & parity_enable_bit} << n)
                 | ({11'h000, ~bstop} << (n + {3'h0, parity_enable_bit}));
    frame_len = n + {3'h0, parity_enable_bit} + 4'h1;
    if (keep)
      expq.push_back({parity_enable_bit & bpar, dorx, bstop, m});
    go = 1'b1;
    wait_busy(1'b1);
    go = 1'b0;
  end
  endtask

  task send(input [8:0] d, input bpar, input bstop, input dorx, input keep);
  begin
    launch(d, bpar, bstop, dorx, keep);
    wait_busy(1'b0);
    repeat (80) @(negedge sys_clk);
  end
  endtask

  // Lets the reader empty the buffer until the flag reads zero, bounded.
  task drain;
    integer k;
  begin
    hold_rd = 1'b0;
    for (k = 0; expq.size() != 0 || receive_complete_flag !== 1'b0; k = k + 1)
    begin
      if (k == 4000)
      begin
        miss("buffer never drained");
        conclude;
      end
      @(negedge sys_clk);
    end
  end
  endtask

  // Reader: status first, then a data read that pops the entry; status is never written.
  initial
  begin
    data_read_strobe = 1'b0;
    forever
    begin
      @(negedge sys_clk);
      if (receive_complete_flag === 1'b1 && !hold_rd)
      begin
        got = {parity_error_flag, overrun_flag, frame_error_flag, received_ninth_bit,
               serial_data_register};
        n_checks = n_checks + 1;
        if (expq.size() == 0)
          miss("entry with no frame sent");
        else if (got !== expq.pop_front())
          miss("buffer entry differs");
        data_read_strobe = 1'b1;
        @(negedge sys_clk);
        data_read_strobe = 1'b0;
        repeat (2) @(negedge sys_clk);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  // Format is only changed while the buffer and the line are idle.
  initial
  begin
    fails = 0;
    n_checks = 0;
    seed = 32'hc84c;
    tdiv = 2'h0;
    sample_tick = 1'b0;
    srst = 1'b1;
    sync_mode = 1'b0;
    go = 1'b0;
    hold_rd = 1'b0;
    receiver_enable_bit = 1'b0;
    double_speed = 1'b0;
    character_size_field = 3'h3;
    parity_enable_bit = 1'b0;
    parity_odd_select_bit = 1'b0;
    stop_bit_count_select = 1'b0;
    receive_complete_irq_enable = 1'b0;
    frame_bits = 12'h000;
    frame_len = 4'h0;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    receiver_enable_bit = 1'b1;
    for (i = 0; i < 12; i = i + 1)
    begin
      r = $random(seed);
      character_size_field = (i % 6 == 4) ? 3'h7 : (i % 6 == 5) ? 3'h5 : 3'(i % 6);
      double_speed = (i >= 6);
      sync_mode = (i == 5);
      parity_enable_bit = (i % 3 != 0);
      parity_odd_select_bit = (i % 3 == 2);
      receive_complete_irq_enable = r[20];
      stop_bit_count_select = r[21];
      send(r[8:0], 1'b0, 1'b0, 1'b0, 1'b1);
      send(r[17:9], 1'b1, r[22], 1'b0, 1'b1);
      drain;
    end
    $display("format sweep done");
    character_size_field = 3'h3;
    parity_enable_bit = 1'b0;
    double_speed = 1'b0;
    hold_rd = 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      r = $random(seed);
      if (i == 4)
        drain;
      send(r[8:0], 1'b0, 1'b0, i == 2, i != 3);
    end
    drain;
    $display("overrun test done");
    hold_rd = 1'b1;
    send(r[16:8], 1'b0, 1'b0, 1'b0, 1'b1);
    send(r[24:16], 1'b0, 1'b0, 1'b0, 1'b1);
    launch(r[30:22], 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (200) @(negedge sys_clk);
    receiver_enable_bit = 1'b0;
    expq.delete();
    repeat (4) @(negedge sys_clk);
    n_checks = n_checks + 1;
    if (receive_complete_flag !== 1'b0 || pin_override !== 1'b0)
      miss("no flush or pin kept");
    wait_busy(1'b0);
    receiver_enable_bit = 1'b1;
    repeat (3) @(negedge sys_clk);
    n_checks = n_checks + 1;
    if (pin_override !== 1'b1)
      miss("pin not claimed");
    hold_rd = 1'b0;
    send(r[8:0], 1'b0, 1'b0, 1'b0, 1'b1);
    drain;
    $display("disable test done");
    conclude;
  end
endmodule // uart_receiver_tb
